// ==== pkg/pbsp_pkg.sv ====
// Constants, types and burst ordering for the pipelined burst SRAM port.
// Assumes one clock and a synchronous active-low reset at the top.
// Overview of operation
// - Second chip enable is sampled each edge, active high, joins selection.
// - Third chip enable is sampled each edge, active low, joins selection.
// - Output enable acts without a clock; low drives data pins, high floats them.
// - First clock of a read leaving deselect keeps data pins floating.
// - Advance sampled low during a burst steps to the next burst address.
// - Processor strobe low captures address and loads low two bits into counter.
// - Controller strobe low captures address and loads low two bits into counter.
// - Both strobes low together: only the processor strobe is acted on.
// - Processor strobe is ignored while the first chip enable is high.
// - Sleep high gives a quiet state that keeps memory contents.
// - An undriven sleep input counts as low, so operation stays normal.
// - Data pins are captured into an input data register each edge.
// - Read data comes from the address taken at the previous edge.
// - Burst order strap low selects linear, high or open selects interleaved.
// - First chip enable is active low, sampled each edge, joins selection.
// - Low two address bits feed a two-bit counter giving later burst addresses.
// - Global write low writes all four bytes regardless of byte controls.
// - Each byte select writes its byte only with byte write enable low.
package pbsp_pkg;
  // ==========================================================
  // Sizes
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 2;
  // ==========================================================
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic DRIVE_RST = 1'h0;
  localparam logic DESEL_RST = 1'h1;
  localparam logic SLEEP_RST = 1'h0;
  localparam logic MODE_LINEAR = 1'h0;
  // ==========================================================
  // Port state
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BURST = 3'h2,
    ST_SLEEP = 3'h4
  } pbsp_state_t;
  // ==========================================================
  // Burst address low bits for a given start and step
  function automatic logic [CNT_W-1:0] burst_low(input logic mode,
      input logic [CNT_W-1:0] base, input logic [CNT_W-1:0] step);
    logic [CNT_W-1:0] res;
    res = (mode == MODE_LINEAR) ? base + step : base ^ step;
    return res;
  endfunction
endpackage

// ==== pkg/pbsp_mem_if.sv ====
// Interface between the port logic and the storage array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pbsp_mem_if #(parameter int AW = pbsp_pkg::ADDR_W,
    parameter int DW = pbsp_pkg::DATA_W);
  localparam int NB = DW / pbsp_pkg::BYTE_W;
  logic [AW-1:0] raddr;
  logic re;
  logic [DW-1:0] rdata;
  logic [AW-1:0] waddr;
  logic [NB-1:0] we;
  logic [DW-1:0] wdata;
  modport ctrl (output raddr, output re, input rdata, output waddr, output we,
    output wdata);
  modport mem (input raddr, input re, output rdata, input waddr, input we,
    input wdata);
endinterface

// ==== design/pbsp_mem.sv ====
// Storage array with byte writes and a registered read port.
// Assumes one clock; a read of a word being written sees the new bytes.
`timescale 1ns/1ps
module pbsp_mem #(
  parameter int AW = pbsp_pkg::ADDR_W,
  parameter int DW = pbsp_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  pbsp_mem_if.mem mem_if
);
  localparam int NB = DW / pbsp_pkg::BYTE_W;
  localparam int BW = pbsp_pkg::BYTE_W;
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  // ==========================================================
  // Read with forwarding of a pending write
  always_comb begin
    rdata_nxt = rdata_r;
    if (!rst_b_in) begin
      rdata_nxt = '0;
    end else if (mem_if.re) begin
      rdata_nxt = store[mem_if.raddr];
      for (int i = 0; i < NB; i++) begin
        if (mem_if.we[i] && (mem_if.waddr == mem_if.raddr)) begin
          rdata_nxt[i*BW +: BW] = mem_if.wdata[i*BW +: BW];
        end
      end
    end
  end
  always_ff @(posedge clk_in) begin
    rdata_r <= rdata_nxt;
  end
  // Byte lane writes
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NB; i++) begin
      if (mem_if.we[i]) begin
        store[mem_if.waddr][i*BW +: BW] <= mem_if.wdata[i*BW +: BW];
      end
    end
  end
  assign mem_if.rdata = rdata_r;
endmodule // pbsp_mem

// ==== design/pbsp_top.sv ====
// Pin-level port of a pipelined burst SRAM: selects, strobes, burst, data.
// Assumes synchronous pins are stable at the clock edge; output enable and
// sleep may change at any time.
`timescale 1ns/1ps
module pbsp_top #(
  parameter int AW = pbsp_pkg::ADDR_W,
  parameter int DW = pbsp_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic select_primary_n_in,
  input wire logic select_expand_hi_in,
  input wire logic select_expand_lo_n_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic write_all_bytes_n_in,
  input wire logic byte_write_enable_n_in,
  input wire logic [DW/pbsp_pkg::BYTE_W-1:0] byte_select_n_in,
  input wire logic out_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_in,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe_out,
  output logic asleep_out
);
  localparam int NB = DW / pbsp_pkg::BYTE_W;
  localparam int CW = pbsp_pkg::CNT_W;

  pbsp_mem_if #(.AW(AW), .DW(DW)) mem_if ();

  pbsp_mem #(.AW(AW), .DW(DW)) pbsp_mem_inst (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mem_if(mem_if)
  );

  pbsp_pkg::pbsp_state_t state_r, state_nxt;
  logic [CW-1:0] base_r, base_nxt;
  logic [CW-1:0] step_r, step_nxt;
  logic [AW-1:CW] hi_r, hi_nxt;
  logic drive_r, drive_nxt;
  logic desel_r, desel_nxt;
  logic mode_r, mode_nxt;
  logic sleep_s1_r, sleep_s2_r, sleep_s3_r, sleep_r, sleep_nxt;
  logic [DW-1:0] dq_in_r;
  logic [AW-1:0] wr_addr_r;
  logic [NB-1:0] wr_be_r, wr_be_nxt;
  logic awake, sel_all, take_proc, take_ctrl, strobe;
  logic acc_now, desel_now, cont, wr_req, wr_now, rd_now, read_first;
  logic [NB-1:0] be;
  logic [CW-1:0] acc_low;
  logic [AW-1:0] acc_addr;

  // ==========================================================
  // Sleep input: three stages, change taken once stages two and three agree
  always_comb begin
    sleep_nxt = sleep_r;
    if (!rst_b_in) begin
      sleep_nxt = pbsp_pkg::SLEEP_RST;
    end else if (sleep_s2_r == sleep_s3_r) begin
      sleep_nxt = sleep_s3_r;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sleep_s1_r <= pbsp_pkg::SLEEP_RST;
      sleep_s2_r <= pbsp_pkg::SLEEP_RST;
      sleep_s3_r <= pbsp_pkg::SLEEP_RST;
    end else begin
      sleep_s1_r <= sleep_request_in;
      sleep_s2_r <= sleep_s1_r;
      sleep_s3_r <= sleep_s2_r;
    end
    sleep_r <= sleep_nxt;
  end

  // ==========================================================
  // Strobe and select decode
  always_comb begin
    awake = (state_r != pbsp_pkg::ST_SLEEP) && !sleep_r;
    sel_all = !select_primary_n_in && select_expand_hi_in
      && !select_expand_lo_n_in;
    take_proc = !proc_addr_strobe_n_in && !select_primary_n_in && awake;
    take_ctrl = !ctrl_addr_strobe_n_in && !take_proc && awake;
    strobe = take_proc || take_ctrl;
    acc_now = strobe && sel_all;
    desel_now = strobe && !sel_all;
    cont = (state_r == pbsp_pkg::ST_BURST) && !strobe && awake;
    // Write lanes: global write overrides the byte controls
    if (!write_all_bytes_n_in) begin
      be = '1;
    end else if (!byte_write_enable_n_in) begin
      be = ~byte_select_n_in;
    end else begin
      be = '0;
    end
    wr_req = |be;
    // Processor strobe cycle ignores write controls
    wr_now = wr_req && (take_ctrl && sel_all || cont);
    rd_now = (acc_now || cont) && !wr_now;
    read_first = acc_now && !wr_now;
  end

  // ==========================================================
  // Burst address: start bits plus two-bit step counter
  always_comb begin
    base_nxt = base_r;
    hi_nxt = hi_r;
    step_nxt = step_r;
    if (!rst_b_in) begin
      base_nxt = pbsp_pkg::CNT_RST;
      hi_nxt = '0;
      step_nxt = pbsp_pkg::CNT_RST;
    end else if (acc_now) begin
      base_nxt = addr_in[CW-1:0];
      hi_nxt = addr_in[AW-1:CW];
      step_nxt = pbsp_pkg::CNT_RST;
    end else if (cont && !burst_advance_n_in) begin
      step_nxt = step_r + 2'h1;
    end
    acc_low = pbsp_pkg::burst_low(mode_r, base_nxt, step_nxt);
    acc_addr = {hi_nxt, acc_low};
  end

  // ==========================================================
  // State, output drive and deselect tracking
  always_comb begin
    state_nxt = state_r;
    drive_nxt = pbsp_pkg::DRIVE_RST;
    desel_nxt = desel_r;
    mode_nxt = mode_r;
    if (!rst_b_in) begin
      state_nxt = pbsp_pkg::ST_IDLE;
      desel_nxt = pbsp_pkg::DESEL_RST;
      mode_nxt = burst_order_in;
    end else if (sleep_r) begin
      state_nxt = pbsp_pkg::ST_SLEEP;
      desel_nxt = 1'h1;
    end else if (state_r == pbsp_pkg::ST_SLEEP) begin
      state_nxt = pbsp_pkg::ST_IDLE;
    end else begin
      if (desel_now) begin
        state_nxt = pbsp_pkg::ST_IDLE;
        desel_nxt = 1'h1;
        // Only a deselect from a selected state holds the drive one more cycle
        drive_nxt = drive_r && !desel_r;
      end else if (acc_now) begin
        state_nxt = pbsp_pkg::ST_BURST;
        desel_nxt = 1'h0;
      end
      if (rd_now) begin
        drive_nxt = 1'h1;
      end
    end
  end
  always_ff @(posedge clk_in) begin
    state_r <= state_nxt;
    base_r <= base_nxt;
    hi_r <= hi_nxt;
    step_r <= step_nxt;
    drive_r <= drive_nxt;
    desel_r <= desel_nxt;
    mode_r <= mode_nxt;
  end

  // ==========================================================
  // Input data register and write stage
  always_comb begin
    wr_be_nxt = (rst_b_in && wr_now) ? be : '0;
  end
  always_ff @(posedge clk_in) begin
    dq_in_r <= dq_in;
    wr_addr_r <= acc_addr;
    wr_be_r <= wr_be_nxt;
  end

  // ==========================================================
  // Memory hookup and pins
  assign mem_if.raddr = acc_addr;
  assign mem_if.re = rd_now;
  assign mem_if.waddr = wr_addr_r;
  assign mem_if.we = wr_be_r;
  assign mem_if.wdata = dq_in_r;
  assign dq_out = mem_if.rdata;
  // Output enable acts at once; masked on writes and the first read cycle after deselect
  assign dq_oe_out = drive_r && !out_enable_n_in
    && !wr_now && !(desel_r && read_first);
  assign asleep_out = (state_r == pbsp_pkg::ST_SLEEP);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_full_write;
    take_ctrl && sel_all && !write_all_bytes_n_in;
  endsequence
  sequence s_same_read;
    take_ctrl && sel_all && write_all_bytes_n_in && byte_write_enable_n_in
      && (addr_in == $past(addr_in));
  endsequence
  sequence s_start_step;
    acc_now ##1 (cont && !burst_advance_n_in);
  endsequence
  sequence s_desel_then_read;
    desel_now ##1 (acc_now && !wr_now);
  endsequence

  read_after_write_a: assert property (s_full_write ##1 s_same_read
      |=> dq_out == $past(dq_in, 2))
    else $error("read data does not match earlier write");
  oe_async_a: assert property (out_enable_n_in |-> !dq_oe_out)
    else $error("data driven with output enable high");
  first_mask_a: assert property (s_desel_then_read |-> !dq_oe_out)
    else $error("data driven on first read cycle after deselect");
  adv_step_a: assert property (cont && !burst_advance_n_in
      |=> step_r == $past(step_r) + 2'h1)
    else $error("burst counter did not step");
  burst_order_a: assert property (s_start_step |-> acc_low ==
      (mode_r ? ($past(addr_in[1:0]) ^ 2'h1) : ($past(addr_in[1:0]) + 2'h1)))
    else $error("wrong second burst address");
  proc_load_a: assert property (take_proc && sel_all
      |=> base_r == $past(addr_in[1:0]) && step_r == 2'h0)
    else $error("processor strobe did not load counter");
  ctrl_load_a: assert property (take_ctrl && sel_all
      |=> hi_r == $past(addr_in[AW-1:CW]) && base_r == $past(addr_in[1:0]))
    else $error("controller strobe did not load address");
  proc_prio_a: assert property (!proc_addr_strobe_n_in && !ctrl_addr_strobe_n_in
      && sel_all && awake && !write_all_bytes_n_in |=> wr_be_r == '0)
    else $error("controller strobe overrode processor strobe");
  prim_ignore_a: assert property (select_primary_n_in && !proc_addr_strobe_n_in
      && ctrl_addr_strobe_n_in |=> hi_r == $past(hi_r) && base_r == $past(base_r))
    else $error("processor strobe taken with first enable high");
  sleep_enter_a: assert property (sleep_request_in [*5]
      |=> state_r == pbsp_pkg::ST_SLEEP && !drive_r)
    else $error("sleep not entered");
  sleep_low_a: assert property (!sleep_request_in [*5]
      |=> state_r != pbsp_pkg::ST_SLEEP)
    else $error("sleep entered with input low");
  global_write_a: assert property (take_ctrl && sel_all && !write_all_bytes_n_in
      |=> wr_be_r == {NB{1'b1}})
    else $error("global write missed bytes");
  byte_gate_a: assert property (take_ctrl && sel_all && write_all_bytes_n_in
      && byte_write_enable_n_in |=> wr_be_r == '0)
    else $error("byte written without byte write enable");
  desel_drain_a: assert property (desel_now ##1 !rd_now |=> !drive_r)
    else $error("data pins still driven after deselect drained");
endmodule // pbsp_top

// ==== verification/pbsp_host_model.sv ====
// Far-side model: holds the burst-order strap and drives the sleep pin.
// Assumes strap_out sits on a pulled-up net and sleep_out on a pulled-down one.
`timescale 1ns/1ps
module pbsp_host_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic linear_in,
  input wire logic sleep_in,
  output wire logic strap_out,
  output wire logic sleep_out
);
  logic linear_r;
  // ==========================================================
  // Strap level may only change while the port is held in reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      linear_r <= linear_in;
    end
  end
  // Grounded for linear order, left open for interleaved
  assign strap_out = linear_r ? 1'b0 : 1'bz;
  // Sleep pin is released, not driven low, when awake
  assign sleep_out = sleep_in ? 1'b1 : 1'bz;
endmodule // pbsp_host_model

// ==== verification/pipelined_burst_sram_port_bench.sv ====
// Self-checking bench for the pipelined burst SRAM port.
// Assumes one 250 MHz clock and the host model for strap and sleep.
`timescale 1ns/1ps
module pipelined_burst_sram_port_bench;
  logic clk_in = 1'b0, rst_b = 1'b0, linear = 1'b1, sleep_req = 1'b0;
  logic p_n = 1'b1, c_n = 1'b1, step_n = 1'b1, allw_n = 1'b1, lane_en_n = 1'b1, oe_n = 1'b0;
  logic sp_n = 1'b0, shi = 1'b1, slo_n = 1'b0, sp_v = 1'b0, shi_v = 1'b1, slo_v = 1'b0;
  logic lane_en_v = 1'b1, oe_v = 1'b0;
  logic [3:0] bs_n = 4'hF, bs_v = 4'hF;
  logic [16:0] addr = 17'h0;
  logic [31:0] dq_host = 32'h0, dq_out;
  logic [31:0] exp_m [0:3];
  logic dq_oe, asleep;
  tri1 strap_w;
  tri0 sleep_w;
  int fails = 0, n_tests = 0;
  wire [31:0] dq_bus = dq_oe ? dq_out : dq_host;
  // ==========================================================
  // Design and far-side model
  pbsp_top pbsp_top_inst (.clk_in(clk_in), .rst_b_in(rst_b), .addr_in(addr),
    .select_primary_n_in(sp_n), .select_expand_hi_in(shi), .select_expand_lo_n_in(slo_n),
    .proc_addr_strobe_n_in(p_n), .ctrl_addr_strobe_n_in(c_n), .burst_advance_n_in(step_n),
    .write_all_bytes_n_in(allw_n), .byte_write_enable_n_in(lane_en_n),
    .byte_select_n_in(bs_n),
    .out_enable_n_in(oe_n), .sleep_request_in(sleep_w), .burst_order_in(strap_w),
    .dq_in(dq_bus), .dq_out(dq_out), .dq_oe_out(dq_oe), .asleep_out(asleep));
  pbsp_host_model pbsp_host_model_inst (.clk_in(clk_in), .rst_b_in(rst_b),
    .linear_in(linear), .sleep_in(sleep_req), .strap_out(strap_w), .sleep_out(sleep_w));
  // Clock and watchdog
  always #2 clk_in = ~clk_in;
  initial begin
    #(3000 * 4);
    fails++;
    summarize();
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Wait for an edge, then present one set of sync pins for the next edge to sample
  task automatic pins(input logic p, input logic c, input logic stp, input logic allw,
      input logic [16:0] a, input logic [31:0] d);
    @(posedge clk_in);
    p_n <= p;
    c_n <= c;
    step_n <= stp;
    allw_n <= allw;
    addr <= a;
    dq_host <= d;
    lane_en_n <= lane_en_v;
    bs_n <= bs_v;
    sp_n <= sp_v;
    shi <= shi_v;
    slo_n <= slo_v;
    oe_n <= oe_v;
    #1;
  endtask
  task automatic idle();
    pins(1'b1, 1'b1, 1'b1, 1'b1, 17'h0, ~dq_host);
  endtask
  task automatic acc(input logic allw, input logic [16:0] a, input logic [31:0] d);
    pins(1'b1, 1'b0, 1'b1, allw, a, d);
  endtask
  task automatic do_reset(input logic lin);
    @(posedge clk_in);
    rst_b <= 1'b0;
    linear <= lin;
    repeat (6) @(posedge clk_in);
    rst_b <= 1'b1;
  endtask
  // Read burst from word 1 with advance low each edge
  task automatic burst(input logic lin);
    logic [1:0] k;
    do_reset(lin);
    acc(1'b1, 17'h101, 32'h0);
    for (int s = 0; s < 4; s++) begin
      pins(1'b1, 1'b1, 1'b0, 1'b1, 17'h0, 32'h0);
      k = lin ? 2'h1 + s[1:0] : 2'h1 ^ s[1:0];
      check(dq_out, exp_m[k]);
      check({31'h0, dq_oe}, 32'h1);
    end
    $display("burst lin=%0d done", lin);
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    do_reset(1'b1);
    for (int i = 0; i < 4; i++) begin
      exp_m[i] = {28'hA0B0C0D, 2'h0, i[1:0]};
      acc(1'b0, {15'h040, i[1:0]}, exp_m[i]);
    end
    acc(1'b1, 17'h103, 32'h0);
    lane_en_v = 1'b0;
    bs_v = 4'hE;
    acc(1'b1, 17'h100, 32'h11223344);
    check(dq_out, exp_m[3]);
    lane_en_v = 1'b1;
    bs_v = 4'h0;
    acc(1'b1, 17'h101, 32'hFFFFFFFF);
    bs_v = 4'hF;
    exp_m[0][7:0] = 8'h44;
    acc(1'b1, 17'h100, 32'h0);
    idle();
    check(dq_out, exp_m[0]);
    acc(1'b1, 17'h101, 32'h0);
    idle();
    check(dq_out, exp_m[1]);
    $display("write test done");
    burst(1'b1);
    burst(1'b0);
    lane_en_v = 1'b0;
    bs_v = 4'h0;
    pins(1'b0, 1'b0, 1'b1, 1'b0, 17'h102, 32'h0);
    lane_en_v = 1'b1;
    bs_v = 4'hF;
    idle();
    check(dq_out, exp_m[2]);
    idle();
    acc(1'b1, 17'h102, 32'h0);
    idle();
    check(dq_out, exp_m[2]);
    $display("strobe priority done");
    for (int j = 0; j < 3; j++) begin
      acc(1'b1, 17'h100, 32'h0);
      sp_v = (j == 0);
      shi_v = (j != 1);
      slo_v = (j == 2);
      acc(1'b1, 17'h100, 32'h0);
      sp_v = 1'b0;
      shi_v = 1'b1;
      slo_v = 1'b0;
      idle();
      check({31'h0, dq_oe}, 32'h1);
      idle();
      check({31'h0, dq_oe}, 32'h0);
    end
    acc(1'b1, 17'h100, 32'h0);
    shi_v = 1'b0;
    acc(1'b1, 17'h100, 32'h0);
    shi_v = 1'b1;
    acc(1'b1, 17'h103, 32'h0);
    check({31'h0, dq_oe}, 32'h0);
    sp_v = 1'b1;
    pins(1'b0, 1'b1, 1'b0, 1'b1, 17'h0, 32'h0);
    sp_v = 1'b0;
    check(dq_out, exp_m[3]);
    idle();
    check(dq_out, exp_m[2]);
    oe_v = 1'b1;
    idle();
    check({31'h0, dq_oe}, 32'h0);
    oe_v = 1'b0;
    $display("select test done");
    shi_v = 1'b0;
    acc(1'b1, 17'h100, 32'h0);
    shi_v = 1'b1;
    @(posedge clk_in) sleep_req <= 1'b1;
    repeat (7) idle();
    check({30'h0, asleep, dq_oe}, 32'h2);
    @(posedge clk_in) sleep_req <= 1'b0;
    repeat (6) idle();
    check({31'h0, asleep}, 32'h0);
    acc(1'b1, 17'h100, 32'h0);
    idle();
    check(dq_out, exp_m[0]);
    $display("sleep test done");
    summarize();
  end
endmodule // pipelined_burst_sram_port_bench
